// ### phy_led_override_and_test_control.v
// LED override and miscellaneous PHY control registers, with LED driving,
// pulse stretching, pause resolution and a pseudo-random self-test engine.
// Assumes register reads/writes arrive as single-cycle strobes on clk_in from
// the management interface, and that status inputs come from clk_in logic.
`timescale 1ns/100ps
`include "phy_led_ctrl_map.vh"

module phy_led_override_and_test_control (
   input wire clk_in, // 25 MHz clock
   input wire sys_rst_in, // Synchronous reset, active high
   input wire reg_wr_in, // Register write strobe
   input wire reg_rd_in, // Register read strobe
   input wire [4:0] reg_addr_in, // Register address
   input wire [15:0] reg_wdata_in, // Write data
   output reg [15:0] reg_rdata_out, // Read data, valid cycle after strobe
   input wire mdix_strap_in, // Crossover strap, pin level
   input wire [15:0] local_advertisement_in, // Local advertisement word
   input wire [15:0] partner_advertisement_in, // Partner advertisement word
   input wire full_duplex_in, // Negotiated result is full duplex
   input wire speed_status_in, // Raw speed LED status
   input wire link_status_in, // Raw link LED status
   input wire activity_status_in, // Raw activity/collision status
   input wire selftest_rx_in, // Looped self-test bit
   output reg selftest_tx_out, // Self-test stream bit
   output reg speed_led_out, // Speed LED
   output reg link_led_out, // Link LED
   output reg activity_collision_led_out, // Activity/collision LED
   output reg auto_crossover_enable_out, // Auto crossover enabled
   output reg crossover_force_out, // Media pairs crossed
   output reg pause_rx_out, // MAC should enable pause receive
   output reg pause_tx_out // MAC should enable pause transmit
);

   reg strap_meta_q, strap_sync_q, strap_taken_q;
   reg [5:0] led_ovr_q;
   reg auto_xover_q, xover_force_q, err_inject_q, long_sel_q, run_q, byp_q, locked_q, failed_q;
   reg [14:0] prbs_tx_q, prbs_rx_q;
   reg [2:0] raw_leds;
   wire [2:0] stretched;
   reg [2:0] normal_leds;
   reg [15:0] misc_rd;
   wire [2:0] force_en;
   wire [2:0] force_val;
   wire pr_local, pa_local, pr_partner, pa_partner;
   wire res_rx, res_tx;
   wire fb_tx, fb_rx, exp_bit;
   wire wr_led, wr_misc;

   assign wr_led = reg_wr_in && (reg_addr_in == `LED_OVR_ADDR);
   assign wr_misc = reg_wr_in && (reg_addr_in == `PHY_MISC_ADDR);

   // Strap passes two flops before being captured once after reset release
   always @(posedge clk_in) begin
      strap_meta_q <= mdix_strap_in;
      strap_sync_q <= strap_meta_q;
   end

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         led_ovr_q <= `LED_OVR_RESET;
         strap_taken_q <= 1'b0;
         auto_xover_q <= 1'b0;
         xover_force_q <= 1'b0;
         err_inject_q <= 1'b0;
         long_sel_q <= 1'b0;
         run_q <= 1'b0;
         byp_q <= 1'b0;
      end else begin
         if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            auto_xover_q <= strap_sync_q;
         end
         if (wr_led) begin
            led_ovr_q <= reg_wdata_in[5:0];
         end
         err_inject_q <= 1'b0;
         if (wr_misc) begin
            if (strap_taken_q) begin
               auto_xover_q <= reg_wdata_in[`XOVER_AUTO_BIT];
            end
            xover_force_q <= reg_wdata_in[`XOVER_FORCE_BIT];
            err_inject_q <= reg_wdata_in[`BIST_ERR_BIT];
            long_sel_q <= reg_wdata_in[`BIST_LONG_BIT];
            run_q <= reg_wdata_in[`BIST_RUN_BIT];
            byp_q <= reg_wdata_in[`STRETCH_BYP_BIT];
         end
      end
   end

   // Standard pause resolution table
   assign pa_local = local_advertisement_in[`ADV_PAUSE_BIT];
   assign pr_local = local_advertisement_in[`ADV_ASYM_BIT];
   assign pa_partner = partner_advertisement_in[`ADV_PAUSE_BIT];
   assign pr_partner = partner_advertisement_in[`ADV_ASYM_BIT];
   assign res_tx = full_duplex_in && ((pa_local && pa_partner) ||
                   (!pa_local && pr_local && pa_partner && pr_partner));
   assign res_rx = full_duplex_in && ((pa_local && pa_partner) ||
                   (pa_local && pr_local && !pa_partner && pr_partner));

   // Self-test: transmit and receive generators; receiver self-synchronises
   assign fb_tx = long_sel_q ? (prbs_tx_q[14] ^ prbs_tx_q[13]) : (prbs_tx_q[8] ^ prbs_tx_q[4]);
   assign fb_rx = long_sel_q ? (prbs_rx_q[14] ^ prbs_rx_q[13]) : (prbs_rx_q[8] ^ prbs_rx_q[4]);
   assign exp_bit = fb_rx;

   // Lock needs a run of good bits counted only once the receiver holds a one,
   // so stale zeros from the idle line can never fake a lock.
   // Limitation: an error forced before lock is absorbed, not reported.
   reg [3:0] match_cnt_q;
   wire [3:0] lock_need;
   wire rx_err;
   assign lock_need = long_sel_q ? `LOCK_LONG_BITS : `LOCK_SHORT_BITS;
   assign rx_err = selftest_rx_in != exp_bit;

   always @(posedge clk_in) begin
      if (sys_rst_in || !run_q) begin
         prbs_tx_q <= long_sel_q ? `PRBS15_SEED : {6'h00, `PRBS9_SEED};
         prbs_rx_q <= 15'h0000;
         selftest_tx_out <= 1'b0;
         match_cnt_q <= 4'h0;
         locked_q <= 1'b0;
         failed_q <= 1'b0;
      end else begin
         prbs_tx_q <= {prbs_tx_q[13:0], fb_tx};
         prbs_rx_q <= {prbs_rx_q[13:0], selftest_rx_in};
         selftest_tx_out <= fb_tx ^ err_inject_q;
         if (locked_q) begin
            if (rx_err) begin
               failed_q <= 1'b1;
            end
         end else if (rx_err || prbs_rx_q == 15'h0000) begin
            match_cnt_q <= 4'h0;
         end else if (match_cnt_q == lock_need) begin
            locked_q <= 1'b1;
         end else begin
            match_cnt_q <= match_cnt_q + 4'h1;
         end
      end
   end

   // LED pulse stretching, one counter per LED
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_stretch
         reg [19:0] cnt_q;
         always @(posedge clk_in) begin
            if (sys_rst_in) begin
               cnt_q <= 20'h00000;
            end else if (raw_leds[i]) begin
               cnt_q <= `STRETCH_CYCLES;
            end else if (cnt_q != 20'h00000) begin
               cnt_q <= cnt_q - 20'h00001;
            end
         end
         assign stretched[i] = raw_leds[i] || (cnt_q != 20'h00000);
      end
   endgenerate

   assign force_en = {led_ovr_q[`SPEED_FORCE_EN_BIT], led_ovr_q[`LINK_FORCE_EN_BIT],
                      led_ovr_q[`ACT_FORCE_EN_BIT]};
   assign force_val = {led_ovr_q[`SPEED_FORCE_VAL_BIT], led_ovr_q[`LINK_FORCE_VAL_BIT],
                       led_ovr_q[`ACT_FORCE_VAL_BIT]};

   always @* begin
      raw_leds = {speed_status_in, link_status_in, activity_status_in};
      normal_leds = byp_q ? raw_leds : stretched;
      misc_rd = 16'h0000;
      misc_rd[`XOVER_AUTO_BIT] = auto_xover_q;
      misc_rd[`XOVER_FORCE_BIT] = xover_force_q;
      misc_rd[`PAUSE_RX_BIT] = pause_rx_out;
      misc_rd[`PAUSE_TX_BIT] = pause_tx_out;
      misc_rd[`BIST_ERR_BIT] = err_inject_q;
      misc_rd[`BIST_LONG_BIT] = long_sel_q;
      misc_rd[`BIST_PASS_BIT] = locked_q && !failed_q;
      misc_rd[`BIST_RUN_BIT] = run_q;
      misc_rd[`STRETCH_BYP_BIT] = byp_q;
   end

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         speed_led_out <= 1'b0;
         link_led_out <= 1'b0;
         activity_collision_led_out <= 1'b0;
         auto_crossover_enable_out <= 1'b0;
         crossover_force_out <= 1'b0;
         pause_rx_out <= 1'b0;
         pause_tx_out <= 1'b0;
         reg_rdata_out <= 16'h0000;
      end else begin
         speed_led_out <= force_en[2] ? force_val[2] : normal_leds[2];
         link_led_out <= force_en[1] ? force_val[1] : normal_leds[1];
         activity_collision_led_out <= force_en[0] ? force_val[0] : normal_leds[0];
         auto_crossover_enable_out <= auto_xover_q;
         crossover_force_out <= xover_force_q;
         pause_rx_out <= res_rx;
         pause_tx_out <= res_tx;
         if (reg_rd_in && reg_addr_in == `LED_OVR_ADDR) begin
            reg_rdata_out <= {10'h000, led_ovr_q};
         end else if (reg_rd_in && reg_addr_in == `PHY_MISC_ADDR) begin
            reg_rdata_out <= misc_rd;
         end else if (reg_rd_in) begin
            reg_rdata_out <= 16'h0000;
         end
      end
   end

endmodule

// ### phy_led_ctrl_map.vh
// Register offsets, field positions and reset values for the LED override
// and miscellaneous PHY control registers. Definitions only.
`ifndef PHY_LED_CTRL_MAP_VH
`define PHY_LED_CTRL_MAP_VH

`define LED_OVR_ADDR 5'h18
`define PHY_MISC_ADDR 5'h19

`define ACT_FORCE_VAL_BIT 0
`define LINK_FORCE_VAL_BIT 1
`define SPEED_FORCE_VAL_BIT 2
`define ACT_FORCE_EN_BIT 3
`define LINK_FORCE_EN_BIT 4
`define SPEED_FORCE_EN_BIT 5

`define STRETCH_BYP_BIT 7
`define BIST_RUN_BIT 8
`define BIST_PASS_BIT 9
`define BIST_LONG_BIT 10
`define BIST_ERR_BIT 11
`define PAUSE_TX_BIT 12
`define PAUSE_RX_BIT 13
`define XOVER_FORCE_BIT 14
`define XOVER_AUTO_BIT 15

`define ADV_PAUSE_BIT 10
`define ADV_ASYM_BIT 11

`define LED_OVR_RESET 6'h00
`define STRETCH_CYCLES 20'hF4240
`define PRBS15_SEED 15'h7FFF
`define PRBS9_SEED 9'h1FF
`define LOCK_LONG_BITS 4'hF
`define LOCK_SHORT_BITS 4'h9

`endif

// ### phy_media_loop.sv
// Media loopback at the far end of the self-test stream.
// Assumes both ends share clk_in; LOOP_DELAY 1 answers promptly, larger is slow.
`timescale 1ns/100ps
module phy_media_loop #(parameter LOOP_DELAY = 1) (
   input wire clk_in, // Clock
   input wire tx_in, // Stream from the block
   output wire rx_out // Stream back to the block
);
   reg [7:0] pipe_q = 8'h00;
   always @(posedge clk_in) begin
      pipe_q <= {pipe_q[6:0], tx_in};
   end
   assign rx_out = pipe_q[LOOP_DELAY-1];
endmodule

// ### phy_led_ctrl_checker.sv
// Port-level checks of the LED override and PHY control registers.
// Sees only top ports; bound from the testbench top file.
`timescale 1ns/100ps
module phy_led_ctrl_checker (
   input wire clk_in, // Clock
   input wire sys_rst_in, // Reset
   input wire reg_wr_in, // Write strobe
   input wire reg_rd_in, // Read strobe
   input wire [4:0] reg_addr_in, // Address
   input wire [15:0] reg_wdata_in, // Write data
   input wire [15:0] reg_rdata_out, // Read data
   input wire full_duplex_in, // Full duplex
   input wire speed_led_out, // Speed LED
   input wire link_led_out, // Link LED
   input wire activity_collision_led_out, // Activity LED
   input wire auto_crossover_enable_out, // Auto crossover
   input wire crossover_force_out, // Pairs crossed
   input wire pause_rx_out, // Pause receive
   input wire pause_tx_out // Pause transmit
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire led_wr = reg_wr_in && reg_addr_in == 5'h18;
   wire misc_wr = reg_wr_in && reg_addr_in == 5'h19;
   chk_speed_force: assert property (led_wr && reg_wdata_in[5] |->
      ##2 speed_led_out == $past(reg_wdata_in[2], 2)) else $error("speed LED not forced");
   chk_link_force: assert property (led_wr && reg_wdata_in[4] |->
      ##2 link_led_out == $past(reg_wdata_in[1], 2)) else $error("link LED not forced");
   chk_act_force: assert property (led_wr && reg_wdata_in[3] |->
      ##2 activity_collision_led_out == $past(reg_wdata_in[0], 2)) else $error("act LED");
   chk_pairs_cross: assert property (misc_wr |->
      ##2 crossover_force_out == $past(reg_wdata_in[14], 2)) else $error("pair cross");
   chk_auto_cross: assert property (misc_wr |->
      ##2 auto_crossover_enable_out == $past(reg_wdata_in[15], 2)) else $error("auto cross");
   chk_half_pause: assert property (!full_duplex_in [*3] |->
      !pause_rx_out && !pause_tx_out) else $error("pause in half duplex");
   chk_led_reserved: assert property (reg_rd_in && reg_addr_in == 5'h18 |=>
      reg_rdata_out[15:6] == 10'h000) else $error("reserved bits set");
   chk_unmapped_read: assert property (reg_rd_in && reg_addr_in != 5'h18 &&
      reg_addr_in != 5'h19 |=> reg_rdata_out == 16'h0000) else $error("unmapped read");
endmodule

// ### phy_led_override_and_test_control_test.sv
// Self-checking bench: register access, LED forcing, pause and self-test.
// Assumes the design, loopback model and checker are compiled first.
`timescale 1ns/100ps
module phy_led_override_and_test_control_test;
   reg clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, mdix_strap_in = 1, rd_d = 0;
   reg full_duplex_in = 0, speed_status_in = 0, link_status_in = 0, activity_status_in = 0;
   reg [4:0] reg_addr_in = 5'h00;
   reg [15:0] reg_wdata_in = 16'h0000, local_advertisement_in = 16'h0000, d;
   reg [15:0] partner_advertisement_in = 16'h0000;
   reg [1:0] p;
   reg [15:0] exp_q [$];
   wire [15:0] reg_rdata_out;
   wire selftest_rx_in, selftest_tx_out, speed_led_out, link_led_out;
   wire activity_collision_led_out, auto_crossover_enable_out, crossover_force_out;
   wire pause_rx_out, pause_tx_out;
   integer mismatches = 0, checked = 0, cyc = 0, i;
   phy_led_override_and_test_control i_dut (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out),
      .mdix_strap_in(mdix_strap_in),
      .local_advertisement_in(local_advertisement_in),
      .partner_advertisement_in(partner_advertisement_in),
      .full_duplex_in(full_duplex_in),
      .speed_status_in(speed_status_in),
      .link_status_in(link_status_in),
      .activity_status_in(activity_status_in),
      .selftest_rx_in(selftest_rx_in),
      .selftest_tx_out(selftest_tx_out),
      .speed_led_out(speed_led_out),
      .link_led_out(link_led_out),
      .activity_collision_led_out(activity_collision_led_out),
      .auto_crossover_enable_out(auto_crossover_enable_out),
      .crossover_force_out(crossover_force_out),
      .pause_rx_out(pause_rx_out),
      .pause_tx_out(pause_tx_out)
   );
   phy_media_loop i_loop (.clk_in(clk_in), .tx_in(selftest_tx_out), .rx_out(selftest_rx_in));
   always #20 clk_in = ~clk_in;
   task chk(input [15:0] seen, input [15:0] want);
      begin
         checked = checked + 1;
         if (seen !== want) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
         end
      end
   endtask
   task conclude;
      begin
         $display("mismatches %0d checked %0d", mismatches, checked);
         if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task access(input w, input [4:0] a, input [15:0] v);
      begin
         @(posedge clk_in) #1;
         reg_wr_in = w;
         reg_rd_in = !w;
         reg_addr_in = a;
         reg_wdata_in = v;
         @(posedge clk_in) #1;
         reg_wr_in = 0;
         reg_rd_in = 0;
      end
   endtask
   task rd(input [4:0] a, input [15:0] want);
      begin
         exp_q.push_back(want);
         access(0, a, 16'h0000);
      end
   endtask
   // Read data is valid the cycle after the strobe is taken
   always @(posedge clk_in) begin
      if (rd_d)
         chk(reg_rdata_out, exp_q.pop_front());
      rd_d <= reg_rd_in;
      cyc = cyc + 1;
      if (cyc == 5000) begin
         mismatches = mismatches + 1;
         conclude;
      end
   end
   initial begin
      d = $urandom(32'hB631);
      repeat (5) @(posedge clk_in);
      #1 sys_rst_in = 0;
      repeat (2) @(posedge clk_in);
      rd(5'h18, 16'h0000);
      rd(5'h19, 16'h8000);
      rd(5'h1A, 16'h0000);
      // Stretch bypass on and bit 15 written low, so crossover enable is cleared
      access(1, 5'h19, 16'h0080);
      for (i = 0; i < 12; i = i + 1) begin
         d = $urandom;
         access(1, 5'h18, d);
         {speed_status_in, link_status_in, activity_status_in} = $urandom;
         repeat (3) @(posedge clk_in);
         #1 chk(speed_led_out, d[5] ? d[2] : speed_status_in);
         chk(link_led_out, d[4] ? d[1] : link_status_in);
         chk(activity_collision_led_out, d[3] ? d[0] : activity_status_in);
         rd(5'h18, d & 16'h003F);
      end
      access(1, 5'h1A, 16'hFFFF);
      rd(5'h18, d & 16'h003F);
      // Stretching on: a one-cycle pulse must outlive itself on the LED
      access(1, 5'h18, 16'h0000);
      access(1, 5'h19, 16'h0000);
      activity_status_in = 1;
      @(posedge clk_in) #1 activity_status_in = 0;
      repeat (20) @(posedge clk_in);
      #1 chk(activity_collision_led_out, 16'h0001);
      access(1, 5'h19, 16'h0080);
      repeat (2) @(posedge clk_in);
      #1 chk(activity_collision_led_out, 16'h0000);
      for (i = 0; i < 32; i = i + 1) begin
         {full_duplex_in, local_advertisement_in[11:10], partner_advertisement_in[11:10]} = i;
         p[1] = i[4] & (i[2] & i[0] | i[2] & i[3] & ~i[0] & i[1]);
         p[0] = i[4] & (i[2] & i[0] | ~i[2] & i[3] & i[0] & i[1]);
         repeat (3) @(posedge clk_in);
         #1 chk({pause_rx_out, pause_tx_out}, p);
         rd(5'h19, {2'b00, p, 12'h080});
      end
      full_duplex_in = 0;
      access(1, 5'h19, 16'hC580);
      repeat (60) @(posedge clk_in);
      #1 chk({auto_crossover_enable_out, crossover_force_out}, 2'b11);
      rd(5'h19, 16'hC780);
      access(1, 5'h19, 16'h4D80);
      repeat (60) @(posedge clk_in);
      rd(5'h19, 16'h4580);
      access(1, 5'h19, 16'h0080);
      access(1, 5'h19, 16'h0180);
      repeat (60) @(posedge clk_in);
      rd(5'h19, 16'h0380);
      repeat (3) @(posedge clk_in);
      conclude;
   end
endmodule
bind phy_led_override_and_test_control phy_led_ctrl_checker i_chk (
   .clk_in(clk_in),
   .sys_rst_in(sys_rst_in),
   .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in),
   .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out),
   .full_duplex_in(full_duplex_in),
   .speed_led_out(speed_led_out),
   .link_led_out(link_led_out),
   .activity_collision_led_out(activity_collision_led_out),
   .auto_crossover_enable_out(auto_crossover_enable_out),
   .crossover_force_out(crossover_force_out),
   .pause_rx_out(pause_rx_out),
   .pause_tx_out(pause_tx_out)
);
